// ### hdl/vfp_params.svh
// vfp_params.svh: offsets, reset values and timing counts of the fault sequencer
// assumes a 40 MHz core clock and converter codes scaled in millivolts
`ifndef VFP_PARAMS_SVH
`define VFP_PARAMS_SVH

`define VFP_CLK_MHZ 40
`define VFP_REG_MAX_CURRENT 8'h21
`define VFP_OCP_DELAY_US 50
`define VFP_OCP_DELAY_CYC (`VFP_OCP_DELAY_US * `VFP_CLK_MHZ)
`define VFP_UV_MARGIN_MV 12'h12C
`define VFP_OV_MARGIN_MV 12'h190
`define VFP_OV_RELEASE_MV 12'h064
`define VFP_OV_START_MV 12'h9C4
`define VFP_MAX_CURRENT_PROGRAM_PIN_FULL_MV 12'h7D0
`define VFP_MAX_CURRENT_PROGRAM_PIN_FULL_A 8'h40
`define VFP_SS_STEP_CYC 40
`define VFP_OVRAMP_STEP_CYC 400

`endif

// ### hdl/vfp_pkg.sv
// vfp_pkg.sv: types of the fault sequencer
// assumes vfp_params.svh supplies the numeric constants
package vfp_pkg;
    typedef enum logic [2:0] {VFP_OFF, VFP_SOFT, VFP_RUN, VFP_OVP, VFP_OCP} vfp_state_t;
endpackage : vfp_pkg

// ### hdl/vfp_sync.sv
// vfp_sync.sv: three-stage synchroniser with agreement filter
// assumes asynchronous level inputs
`timescale 1ns/1ps
module vfp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;
    genvar i;

    // per-bit filter: change accepted once stage two and three agree
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_comb
            begin
                out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
            end
        end
    endgenerate

    // register stages
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule : vfp_sync

// ### hdl/vfp_sequencer.sv
// vfp_sequencer.sv: soft start, fault latching and pin sampling for the regulator
// assumes analog comparators and converter codes arrive asynchronously, codes
// are held stable by the converter while its valid level is high
//
// Summary of operation
// R01: over-limit current for 50 us continuous latches an over-current shutdown.
// R02: current at or above 150 percent shuts down at once.
// R03: over-current shutdown holds outputs off until supply or enable cycles.
// R04: over-limit means limit-pin current exceeds the 10 uA reference current.
// R05: output below reference minus droop by margin drives ready low.
// R06: margin defaults to 300 mV, replaced by software configuration value.
// R07: output above reference by 400 mV drops ready and ramps reference down.
// R08: over-voltage forces high gate off, low gate on until output is 100 mV.
// R09: over-voltage state holds until supply or enable cycles.
// R10: during start-up the over-voltage threshold is a fixed 2.5 V.
// R11: soft start steps the reference code from zero to target at fixed rate.
// R12: ramp-supply lockout counts only while enabled.
// R13: on enable, sample max-current pin once, value equals mV times 64/2000.
// R14: current-report pin digitised, 2 V equals full maximum load.
// R15: temperature input digitised for comparison with thermal thresholds.
// R16: phase comparator output drives the gate driver as the single PWM.
// R17: controller, driver and bootstrap supplies monitored for undervoltage.
// R18: host clears over-current by driving enable low then high.
// R19: ready stays low during any latched fault or soft-start ramp.
// R20: enable toggle or supply return clears faults and restarts from zero.
`timescale 1ns/1ps
`include "vfp_params.svh"
module vfp_sequencer
    import vfp_pkg::*;
#(
    parameter int OCP_DELAY_CYC = `VFP_OCP_DELAY_CYC,
    parameter int SS_STEP_CYC = `VFP_SS_STEP_CYC,
    parameter int OVRAMP_STEP_CYC = `VFP_OVRAMP_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable_pin,
    input wire logic vcc_ok,
    input wire logic drv_vcc_ok,
    input wire logic bootstrap_supply_ok,
    input wire logic ramp_supply_sense_ok,
    input wire logic limit_over_ref,
    input wire logic limit_over_150,
    input wire logic pwm_cmp,
    input wire logic adc_valid,
    input wire logic [11:0] vout_mv,
    input wire logic [11:0] droop_mv,
    input wire logic [11:0] max_current_program_pin,
    input wire logic [11:0] current_report_mv,
    input wire logic [11:0] temperature_sense_input,
    input wire logic [11:0] target_code,
    input wire logic [11:0] ready_low_limit,
    input wire logic ready_low_limit_en,
    input wire logic [7:0] reg_addr,
    output logic [7:0] reg_rdata,
    output logic regulator_ready_out,
    output logic gate_pwm,
    output logic high_gate_off,
    output logic low_gate_on,
    output logic shutdown,
    output logic [11:0] dac_code,
    output logic [7:0] max_current_value,
    output logic [7:0] current_report_code,
    output logic [11:0] temperature_code
);
    // refuse counts that the 16-bit counters cannot hold
    if (OCP_DELAY_CYC < 1 || SS_STEP_CYC < 1 || OVRAMP_STEP_CYC < 1 ||
        OCP_DELAY_CYC > 65535 || SS_STEP_CYC > 65536 || OVRAMP_STEP_CYC > 65536)
    begin : g_bad_count
        $error("vfp_sequencer: counts out of range for the 16-bit counters");
    end

    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    logic [8:0] raw_s, syn;
    logic en_s, vcc_s, drv_s, bst_s, rmp_s, ocl_s, ocf_s, pwm_s, adv_s;
    assign raw_s = {enable_pin, vcc_ok, drv_vcc_ok, bootstrap_supply_ok,
                    ramp_supply_sense_ok, limit_over_ref, limit_over_150, pwm_cmp, adc_valid};
    vfp_sync #(.W(9)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(raw_s),
        .dout(syn)
    );
    assign {en_s, vcc_s, drv_s, bst_s, rmp_s, ocl_s, ocf_s, pwm_s, adv_s} = syn;

    // ----------------------------------------------------------------
    // supply qualification
    // ----------------------------------------------------------------
    logic supplies_ok, en_prev_q, power_ok_q, restart;
    // lockout on controller, driver and bootstrap supplies, hysteresis is analog
    assign supplies_ok = vcc_s && drv_s && bst_s; // [R17]
    // ramp lockout only matters once enabled
    logic run_ok;
    assign run_ok = supplies_ok && en_s && rmp_s; // [R12]
    // rising enable or supply return restarts the sequence
    assign restart = (en_s && !en_prev_q) || (supplies_ok && !power_ok_q); // [R20] [R18]

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    vfp_state_t st_q, st_d;
    logic [11:0] dac_q, dac_d;
    logic [15:0] tmr_q, tmr_d;
    logic [15:0] ocp_q, ocp_d;
    logic [7:0] max_current_program_pin_q, max_current_program_pin_d;
    logic max_current_program_pin_done_q, max_current_program_pin_done_d;
    logic [11:0] uv_margin, ov_level, uv_level;
    logic uv_trip, ov_trip, ov_low;
    logic [19:0] max_current_program_pin_prod;

    // under-voltage margin, software value overrides default
    assign uv_margin = ready_low_limit_en ? ready_low_limit : `VFP_UV_MARGIN_MV; // [R06]
    assign uv_level = ({1'b0, dac_q} > 13'(droop_mv) + 13'(uv_margin))
                    ? 12'(dac_q - droop_mv - uv_margin)
                                                    : 12'h0000;
    assign uv_trip = adv_s && (vout_mv < uv_level); // [R05]
    // fixed start-up threshold while ramping, relative one in run
    assign ov_level = (st_q == VFP_SOFT) ? `VFP_OV_START_MV // [R10]
                                         : 12'(dac_q + `VFP_OV_MARGIN_MV); // [R07]
    assign ov_trip = adv_s && (vout_mv > ov_level);
    assign ov_low = adv_s && (vout_mv <= `VFP_OV_RELEASE_MV);
    // full-scale pin voltage maps to 64 A
    assign max_current_program_pin_prod = 20'(max_current_program_pin) * 20'(`VFP_MAX_CURRENT_PROGRAM_PIN_FULL_A);

    // next-state computation
    always_comb
    begin
        st_d = st_q;
        dac_d = dac_q;
        tmr_d = tmr_q;
        ocp_d = ocp_q;
        max_current_program_pin_d = max_current_program_pin_q;
        max_current_program_pin_done_d = max_current_program_pin_done_q;
        if (!run_ok || restart)
        begin
            st_d = restart && run_ok ? VFP_SOFT : VFP_OFF; // [R20]
            dac_d = 12'h0000;
            tmr_d = 16'h0000;
            ocp_d = 16'h0000;
            if (!en_s)
                max_current_program_pin_done_d = 1'b0;
        end
        else
        begin
            // one sample of the programming pin per enable
            if (!max_current_program_pin_done_q && adv_s)
            begin
                max_current_program_pin_d = 8'(max_current_program_pin_prod / 20'(`VFP_MAX_CURRENT_PROGRAM_PIN_FULL_MV)); // [R13]
                max_current_program_pin_done_d = 1'b1;
            end
            // latch-off counter on over-limit current
            if ((st_q == VFP_SOFT || st_q == VFP_RUN) && ocl_s) // [R04]
                ocp_d = 16'(ocp_q + 16'h0001);
            else
                ocp_d = 16'h0000;
            unique case (st_q)
                VFP_OFF:
                begin
                    st_d = VFP_SOFT;
                    dac_d = 12'h0000;
                end
                VFP_SOFT, VFP_RUN:
                begin
                    if (ov_trip)
                    begin
                        st_d = VFP_OVP;
                        tmr_d = 16'h0000;
                    end
                    else if (ocf_s || 32'(ocp_d) >= OCP_DELAY_CYC) // [R02] [R01]
                        st_d = VFP_OCP;
                    else if (st_q == VFP_SOFT)
                    begin
                        // stepped ramp toward target
                        if (32'(tmr_q) >= SS_STEP_CYC - 1) // [R11]
                        begin
                            tmr_d = 16'h0000;
                            if (dac_q < target_code)
                                dac_d = 12'(dac_q + 12'h001);
                            else
                                st_d = VFP_RUN;
                        end
                        else
                            tmr_d = 16'(tmr_q + 16'h0001);
                    end
                    else
                        dac_d = target_code;
                end
                VFP_OVP:
                begin
                    // slow reference ramp down, held until restart
                    if (32'(tmr_q) >= OVRAMP_STEP_CYC - 1) // [R07] [R09]
                    begin
                        tmr_d = 16'h0000;
                        if (dac_q != 12'h0000)
                            dac_d = 12'(dac_q - 12'h001);
                    end
                    else
                        tmr_d = 16'(tmr_q + 16'h0001);
                end
                VFP_OCP:
                    st_d = VFP_OCP; // held until restart [R03]
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output and status registers
    // ----------------------------------------------------------------
    logic rdy_q, rdy_d, pwm_q, pwm_d, hgo_q, hgo_d, lgo_q, lgo_d, sd_q, sd_d;
    logic ovhold_q, ovhold_d;
    logic [7:0] crep_q, crep_d, rd_q, rd_d;
    logic [11:0] temp_q, temp_d;

    // outputs follow state
    always_comb
    begin
        // low gate held on until output falls to release level
        ovhold_d = ovhold_q;
        if (st_d != VFP_OVP)
            ovhold_d = 1'b0;
        else if (st_q != VFP_OVP)
            ovhold_d = 1'b1;
        else if (ov_low)
            ovhold_d = 1'b0; // [R08]
        // high gate stays off for the whole protection state, not only while low gate pulls
        hgo_d = ovhold_d || st_d == VFP_OVP || st_d == VFP_OCP || st_d == VFP_OFF; // [R08] [R09] [R03]
        lgo_d = ovhold_d; // [R08]
        sd_d = st_d == VFP_OCP || st_d == VFP_OFF; // [R03]
        pwm_d = (st_d == VFP_SOFT || st_d == VFP_RUN) && pwm_s; // [R16]
        rdy_d = st_d == VFP_RUN && !uv_trip && !ov_trip; // [R19] [R05] [R07]
        // report scaled so 2 V is 255 counts
        crep_d = crep_q;
        temp_d = temp_q;
        if (adv_s)
        begin
            crep_d = (current_report_mv >= `VFP_MAX_CURRENT_PROGRAM_PIN_FULL_MV) ? 8'hFF
                   : 8'((20'(current_report_mv) * 20'h000FF) / 20'(`VFP_MAX_CURRENT_PROGRAM_PIN_FULL_MV)); // [R14]
            temp_d = temperature_sense_input; // [R15]
        end
        rd_d = (reg_addr == `VFP_REG_MAX_CURRENT) ? max_current_program_pin_d : 8'h00;
    end

    // register all state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= VFP_OFF;
            dac_q <= 12'h0000;
            tmr_q <= 16'h0000;
            ocp_q <= 16'h0000;
            max_current_program_pin_q <= 8'h00;
            max_current_program_pin_done_q <= 1'b0;
            en_prev_q <= 1'b0;
            power_ok_q <= 1'b0;
            rdy_q <= 1'b0;
            pwm_q <= 1'b0;
            hgo_q <= 1'b1;
            lgo_q <= 1'b0;
            sd_q <= 1'b1;
            ovhold_q <= 1'b0;
            crep_q <= 8'h00;
            temp_q <= 12'h0000;
            rd_q <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
            dac_q <= dac_d;
            tmr_q <= tmr_d;
            ocp_q <= ocp_d;
            max_current_program_pin_q <= max_current_program_pin_d;
            max_current_program_pin_done_q <= max_current_program_pin_done_d;
            en_prev_q <= en_s;
            power_ok_q <= supplies_ok;
            rdy_q <= rdy_d;
            pwm_q <= pwm_d;
            hgo_q <= hgo_d;
            lgo_q <= lgo_d;
            sd_q <= sd_d;
            ovhold_q <= ovhold_d;
            crep_q <= crep_d;
            temp_q <= temp_d;
            rd_q <= rd_d;
        end
    end

    assign regulator_ready_out = rdy_q;
    assign gate_pwm = pwm_q;
    assign high_gate_off = hgo_q;
    assign low_gate_on = lgo_q;
    assign shutdown = sd_q;
    assign dac_code = dac_q;
    assign max_current_value = max_current_program_pin_q;
    assign current_report_code = crep_q;
    assign temperature_code = temp_q;
    assign reg_rdata = rd_q;
endmodule : vfp_sequencer

// ### verification/vfp_sequencer_props.sv
// vfp_sequencer_props.sv: port-level timing checks of the fault sequencer
// assumes bind into vfp_sequencer, one clock, synchronous active-low reset
`timescale 1ns/1ps
module vfp_seq_props #(
    parameter int OCP_DELAY_CYC = 2000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable_pin,
    input wire logic vcc_ok,
    input wire logic drv_vcc_ok,
    input wire logic bootstrap_supply_ok,
    input wire logic ramp_supply_sense_ok,
    input wire logic limit_over_ref,
    input wire logic limit_over_150,
    input wire logic pwm_cmp,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic regulator_ready_out,
    input wire logic gate_pwm,
    input wire logic high_gate_off,
    input wire logic low_gate_on,
    input wire logic shutdown,
    input wire logic [11:0] dac_code,
    input wire logic [7:0] max_current_value
);
    // ----------------
    // helper counters
    // ----------------
    logic [3:0] hold_q, hold_d;
    logic [11:0] ref_q, ref_d;
    logic ok;
    assign ok = enable_pin & vcc_ok & drv_vcc_ok & bootstrap_supply_ok & ramp_supply_sense_ok;
    // saturating counts of steady enable and of steady over-limit current
    always_comb
    begin
        hold_d = !ok ? 4'h0 : (hold_q == 4'hF ? hold_q : hold_q + 4'h1);
        ref_d = !limit_over_ref ? 12'h000 : (ref_q == 12'hFFF ? ref_q : ref_q + 12'h001);
    end
    always_ff @(posedge clk)
    begin
        hold_q <= !rst_n ? 4'h0 : hold_d;
        ref_q <= !rst_n ? 12'h000 : ref_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence fast_s;
        limit_over_150 [*8];
    endsequence
    sequence pwm_s;
        (pwm_cmp && !shutdown && !high_gate_off) [*6];
    endsequence
    // ----------------
    // assertions
    // ----------------
    slow_trip_a: assert property (ref_q == OCP_DELAY_CYC + 8 |-> shutdown)
        else $error("long over-limit current left running");
    fast_trip_a: assert property (fast_s |-> shutdown)
        else $error("fast over-current not shut down");
    ocp_hold_a: assert property (shutdown && hold_q == 4'hF |=> shutdown)
        else $error("shutdown released with enable steady");
    ovp_hold_a: assert property (low_gate_on && hold_q == 4'hF |=> high_gate_off)
        else $error("over-voltage state released");
    gate_pair_a: assert property (low_gate_on |-> high_gate_off && !gate_pwm)
        else $error("low gate on without high gate off");
    ready_ovp_a: assert property (low_gate_on [*2] |-> !regulator_ready_out)
        else $error("ready high during over-voltage");
    ready_ocp_a: assert property (shutdown [*2] |-> !regulator_ready_out)
        else $error("ready high during shutdown");
    pwm_follow_a: assert property (pwm_s |-> gate_pwm)
        else $error("gate pwm not following comparator");
    dac_step_a: assert property (!shutdown && !high_gate_off && $past(!shutdown && !high_gate_off)
        |-> dac_code - $past(dac_code) <= 12'h001)
        else $error("dac stepped by more than one");
    reg_read_a: assert property (reg_rdata ==
        ($past(reg_addr) == 8'h21 ? max_current_value : 8'h00))
        else $error("register read data wrong");
endmodule : vfp_seq_props
bind vfp_sequencer vfp_seq_props #(.OCP_DELAY_CYC(OCP_DELAY_CYC)) u_props (
    .clk(clk),
    .rst_n(rst_n),
    .enable_pin(enable_pin),
    .vcc_ok(vcc_ok),
    .drv_vcc_ok(drv_vcc_ok),
    .bootstrap_supply_ok(bootstrap_supply_ok),
    .ramp_supply_sense_ok(ramp_supply_sense_ok),
    .limit_over_ref(limit_over_ref),
    .limit_over_150(limit_over_150),
    .pwm_cmp(pwm_cmp),
    .reg_addr(reg_addr),
    .reg_rdata(reg_rdata),
    .regulator_ready_out(regulator_ready_out),
    .gate_pwm(gate_pwm),
    .high_gate_off(high_gate_off),
    .low_gate_on(low_gate_on),
    .shutdown(shutdown),
    .dac_code(dac_code),
    .max_current_value(max_current_value)
);

// ### verification/vfp_stage_model.sv
// vfp_stage_model.sv: power stage and output converter seen by the sequencer
// assumes gate controls from the sequencer and an output offset set by the bench
`timescale 1ns/1ps
module vfp_stage_model (
    input wire logic clk,
    input wire logic [11:0] dac_code,
    input wire logic high_gate_off,
    input wire logic signed [12:0] offs,
    output logic adc_valid,
    output logic [11:0] vout_mv
);
    logic [1:0] ph_q = 2'h0;
    logic signed [13:0] tgt;
    assign tgt = $signed({2'h0, dac_code}) + offs;
    assign adc_valid = (ph_q != 2'h0);
    // output starts discharged so the drain path never sees an unknown
    initial vout_mv = 12'h000;
    // code changes only as valid drops; gates off drain the output
    always @(posedge clk)
    begin
        ph_q <= ph_q + 2'h1;
        if (ph_q == 2'h3)
            if (high_gate_off)
                vout_mv <= (vout_mv > 12'h020) ? vout_mv - 12'h020 : 12'h000;
            else
                vout_mv <= (tgt < 0) ? 12'h000 : (tgt > 14'sh0FFF) ? 12'hFFF : tgt[11:0];
    end
endmodule : vfp_stage_model

// ### verification/tb.sv
// tb.sv: random and corner tests of the fault sequencer with a stage model
// assumes vfp_sequencer with shortened counts, 40 MHz clock, sync reset
`timescale 1ns/1ps
module tb;
    localparam int OVERCURRENT_PROTECT = 20;
    logic clk = 1'b0, rst_n = 1'b0, enable_pin = 1'b0, vcc_ok = 1'b1, drv_vcc_ok = 1'b1;
    logic bootstrap_supply_ok = 1'b1, ramp_supply_sense_ok = 1'b1, limit_over_ref = 1'b0;
    logic limit_over_150 = 1'b0, pwm_cmp = 1'b0, ready_low_limit_en = 1'b0, adc_valid;
    logic [11:0] droop_mv = 12'h000, max_current_program_pin = 12'h000, m, vout_mv;
    logic [11:0] current_report_mv = 12'h000, temperature_sense_input = 12'h000;
    logic [11:0] target_code = 12'h000, ready_low_limit = 12'h000, dac_code, temperature_code;
    logic [7:0] reg_addr = 8'h21, reg_rdata, max_current_value, current_report_code;
    logic regulator_ready_out, gate_pwm, high_gate_off, low_gate_on, shutdown, seen;
    logic signed [12:0] offs = 13'h0000;
    int fails = 0, n_tests = 0, cyc = 0, seed = 14, i;
    always #12.5 clk = ~clk;
    vfp_sequencer #(.OCP_DELAY_CYC(OVERCURRENT_PROTECT), .SS_STEP_CYC(4), .OVRAMP_STEP_CYC(4)) dut (
        .clk(clk),
        .rst_n(rst_n),
        .enable_pin(enable_pin),
        .vcc_ok(vcc_ok),
        .drv_vcc_ok(drv_vcc_ok),
        .bootstrap_supply_ok(bootstrap_supply_ok),
        .ramp_supply_sense_ok(ramp_supply_sense_ok),
        .limit_over_ref(limit_over_ref),
        .limit_over_150(limit_over_150),
        .pwm_cmp(pwm_cmp),
        .adc_valid(adc_valid),
        .vout_mv(vout_mv),
        .droop_mv(droop_mv),
        .max_current_program_pin(max_current_program_pin),
        .current_report_mv(current_report_mv),
        .temperature_sense_input(temperature_sense_input),
        .target_code(target_code),
        .ready_low_limit(ready_low_limit),
        .ready_low_limit_en(ready_low_limit_en),
        .reg_addr(reg_addr),
        .reg_rdata(reg_rdata),
        .regulator_ready_out(regulator_ready_out),
        .gate_pwm(gate_pwm),
        .high_gate_off(high_gate_off),
        .low_gate_on(low_gate_on),
        .shutdown(shutdown),
        .dac_code(dac_code),
        .max_current_value(max_current_value),
        .current_report_code(current_report_code),
        .temperature_code(temperature_code)
    );
    vfp_stage_model u_stage (.clk(clk), .dac_code(dac_code), .high_gate_off(high_gate_off),
        .offs(offs), .adc_valid(adc_valid), .vout_mv(vout_mv));
    // ----------------
    // helpers
    // ----------------
    task automatic cy(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cy
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    function automatic int rnd(input int lo, input int span);
        return lo + int'($unsigned($random(seed)) % span);
    endfunction : rnd
    function automatic logic [7:0] max_current_program_pin_exp(input logic [11:0] mv);
        return 8'((32'(mv) * 64) / 2000);
    endfunction : max_current_program_pin_exp
    task automatic start();
        enable_pin = 1'b0;
        cy(8);
        enable_pin = 1'b1;
        cy(8);
        cmp(dac_code < 12'h004, 1'b1, "dac restarts low");
        for (int k = 0; k < 6000 && regulator_ready_out !== 1'b1; k++) cy(1);
        cmp(regulator_ready_out, 1'b1, "ready after start");
    endtask : start
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    // cycle count, comparator toggling and hang limit
    always @(posedge clk)
    begin
        cyc++;
        #2 pwm_cmp = cyc[3];
        if (cyc == 80000)
        begin
            fails++;
            close_out();
        end
    end
    // ----------------
    // main sequence
    // ----------------
    initial
    begin
        cy(2);
        rst_n = 1'b1;
        cy(4);
        for (int r = 0; r < 3; r++)
        begin
            // disable first so a new target never jumps the running reference
            enable_pin = 1'b0;
            cy(8);
            target_code = 12'(rnd(600, 300));
            max_current_program_pin = 12'(rnd(0, 2000));
            droop_mv = 12'(rnd(0, 60));
            ready_low_limit = 12'(rnd(100, 300));
            ready_low_limit_en = r[0];
            temperature_sense_input = 12'(rnd(0, 4000));
            current_report_mv = (r == 0) ? 12'h07D0 : 12'h000;
            start();
            cmp(dac_code, target_code, "dac at target");
            cmp(reg_rdata, max_current_program_pin_exp(max_current_program_pin), "max current");
            cmp(current_report_code, (r == 0) ? 8'hFF : 8'h00, "report code");
            cmp(temperature_code, temperature_sense_input, "temperature code");
            m = ready_low_limit_en ? ready_low_limit : 12'h12C;
            offs = -13'(droop_mv + m + 12'h032);
            cy(24);
            cmp(regulator_ready_out, 1'b0, "under-voltage");
            offs = 13'h0032 - 13'(droop_mv + m);
            cy(24);
            cmp(regulator_ready_out, 1'b1, "inside margin");
            offs = 13'h0000;
            $display("test start %0d done", r);
        end
        reg_addr = 8'h22;
        cy(3);
        cmp(reg_rdata, 8'h00, "unmapped read");
        limit_over_ref = 1'b1;
        cy(OVERCURRENT_PROTECT - 8);
        limit_over_ref = 1'b0;
        cy(10);
        cmp(shutdown, 1'b0, "short burst");
        limit_over_ref = 1'b1;
        cy(OVERCURRENT_PROTECT + 10);
        limit_over_ref = 1'b0;
        cmp(shutdown, 1'b1, "slow trip");
        cy(50);
        cmp({shutdown, regulator_ready_out}, 2'b10, "latched");
        start();
        limit_over_150 = 1'b1;
        cy(8);
        cmp(shutdown, 1'b1, "fast trip");
        limit_over_150 = 1'b0;
        start();
        $display("test over-current done");
        for (int k = 0; k < 3; k++)
        begin
            {vcc_ok, drv_vcc_ok, bootstrap_supply_ok} = ~(3'h1 << k);
            cy(10);
            cmp(shutdown, 1'b1, "supply loss");
            {vcc_ok, drv_vcc_ok, bootstrap_supply_ok} = 3'h7;
            cy(10);
            cmp(dac_code < 12'h004, 1'b1, "restart on supply");
        end
        ramp_supply_sense_ok = 1'b0;
        enable_pin = 1'b0;
        cy(8);
        enable_pin = 1'b1;
        cy(20);
        cmp(shutdown, 1'b1, "ramp lockout");
        ramp_supply_sense_ok = 1'b1;
        start();
        $display("test supplies done");
        // pre-charged output: watch the whole ramp for a false trip
        enable_pin = 1'b0;
        cy(8);
        offs = 13'h03E8;
        enable_pin = 1'b1;
        cy(8);
        seen = 1'b0;
        for (i = 0; i < 6000 && dac_code !== target_code; i++)
        begin
            cy(1);
            seen = seen | high_gate_off;
        end
        cmp(seen, 1'b0, "pre-charged start");
        cy(20);
        cmp({high_gate_off, low_gate_on, regulator_ready_out}, 3'h6, "over-voltage");
        for (i = 0; i < 3000 && low_gate_on !== 1'b0; i++) cy(1);
        cmp(vout_mv <= 12'h064, 1'b1, "low gate release");
        cy(50);
        cmp(high_gate_off & (dac_code < target_code), 1'b1, "ramp down held");
        offs = 13'h0A28;
        enable_pin = 1'b0;
        cy(8);
        enable_pin = 1'b1;
        cy(40);
        cmp(high_gate_off & low_gate_on, 1'b1, "start-up limit");
        offs = 13'h0000;
        start();
        $display("test over-voltage done");
        close_out();
    end
endmodule : tb
